// file: design/qfp_pipeline.v
`timescale 1ns/10ps
`default_nettype none
`include "qfp_defines.vh"
module qfp_pipeline #(
    parameter PC_W = `QFP_PC_W
) (
    input wire clk,
    input wire rst_n,
    input wire [15:0] pmem_rdata,
    input wire [7:0] dmem_rdata,
    input wire tptr_load,
    input wire [PC_W-1:0] tptr_value,
    output wire [3:0] phase,
    output reg [PC_W-1:0] pc_r,
    output reg [PC_W-1:0] pmem_addr_r,
    output reg [11:0] dmem_raddr_r,
    output reg dmem_rd_r,
    output reg [11:0] dmem_waddr_r,
    output reg [7:0] dmem_wdata_r,
    output reg dmem_we_r,
    output reg [15:0] instruction_latch_r,
    output reg exec_valid_r,
    output reg exec_other_r,
    output reg [7:0] table_read_latch_r,
    output reg [PC_W-1:0] table_byte_pointer_r,
    output reg ptr_load_r,
    output reg [1:0] ptr_sel_r,
    output reg [11:0] ptr_value_r,
    output reg call_push_r,
    output reg [PC_W-1:0] call_return_r
);

// ==========================================================================
// phase generator
wire [3:0] ph;

qfp_phase_gen u_phase (
    .clk(clk),
    .rst_n(rst_n),
    .phase_r(ph)
);

assign phase = ph;

wire q1 = ph[0];
wire q2 = ph[1];
wire q3 = ph[2];
wire q4 = ph[3];

// ==========================================================================
// pipeline state
reg [15:0] prefetch_r;
reg pre_valid_r;
reg pre_second_r;
reg [PC_W-1:0] pre_pc_r;
reg [PC_W-1:0] fetch_pc_r;
reg exec_second_r;
reg [PC_W-1:0] exec_pc_r;
reg [15:0] word1_r;
reg [7:0] move_data_r;
reg tbl_busy_r;

// ==========================================================================
// decode of the latched word
wire [15:0] il = instruction_latch_r;
wire first_ok = exec_valid_r && !exec_second_r;
wire is_jump = first_ok && (il[15:8] == `QFP_OP_JUMP);
wire is_call = first_ok && (il[15:9] == `QFP_OP_CALL);
wire is_move = first_ok && (il[15:12] == `QFP_OP_MOVE);
wire is_ptr = first_ok && (il[15:8] == `QFP_OP_PTR) && (il[7:6] == 2'b00);
wire is_bra = first_ok && (il[15:11] == `QFP_OP_BRA);
wire is_tbl = first_ok && (il[15:1] == `QFP_OP_TBLRD);
wire is_lone_tail = first_ok && (il[15:12] == `QFP_SECOND_TAG);
wire is_two_word = is_jump || is_call || is_move || is_ptr;
wire is_other = first_ok && !is_two_word && !is_bra && !is_tbl && !is_lone_tail;

// word target from both words, lowest bit zero
wire [PC_W-1:0] abs_target = {pmem_rdata[11:0], il[7:0], 1'b0};

// signed word offset scaled to bytes, relative to the following word
wire [PC_W-1:0] rel_disp = {{(PC_W-12){il[10]}}, il[10:0], 1'b0};
wire [PC_W-1:0] rel_target = exec_pc_r + `QFP_PC_STEP + rel_disp;

wire redirect = is_jump || is_call || is_bra;

// ==========================================================================
// program counter and fetch
always @(posedge clk) begin
    if (!rst_n) begin
        pc_r <= `QFP_RESET_VECTOR;
        fetch_pc_r <= `QFP_RESET_VECTOR;
        pmem_addr_r <= `QFP_RESET_VECTOR;
        prefetch_r <= `QFP_NOP_WORD;
        pre_valid_r <= 1'b0;
        pre_second_r <= 1'b0;
        pre_pc_r <= `QFP_RESET_VECTOR;
    end else begin
        if (q1) begin
            fetch_pc_r <= pc_r;
            pmem_addr_r <= pc_r;
            pc_r <= pc_r + `QFP_PC_STEP;
        end
        if (q2 && is_tbl) begin
            pmem_addr_r <= table_byte_pointer_r;
        end
        if (q3) begin
            // port is shared; hand it back before the fetch is captured
            pmem_addr_r <= fetch_pc_r;
        end
        if (q4) begin
            prefetch_r <= pmem_rdata;
            pre_pc_r <= fetch_pc_r;
            pre_second_r <= is_two_word;
            // two-word redirect keeps its tail slot, a branch discards it
            pre_valid_r <= !is_bra;
            if (is_jump || is_call) begin
                pc_r <= abs_target;
            end else if (is_bra) begin
                pc_r <= rel_target;
            end
        end
    end
end

// ==========================================================================
// execute slot
always @(posedge clk) begin
    if (!rst_n) begin
        instruction_latch_r <= `QFP_NOP_WORD;
        exec_valid_r <= 1'b0;
        exec_second_r <= 1'b0;
        exec_pc_r <= `QFP_RESET_VECTOR;
        word1_r <= `QFP_NOP_WORD;
    end else if (q1) begin
        instruction_latch_r <= prefetch_r;
        exec_valid_r <= pre_valid_r;
        exec_second_r <= pre_second_r;
        exec_pc_r <= pre_pc_r;
        if (first_ok) begin
            word1_r <= il;
        end
    end
end

// ==========================================================================
// data memory strobes
always @(posedge clk) begin
    if (!rst_n) begin
        dmem_raddr_r <= 12'h000;
        dmem_rd_r <= 1'b0;
        dmem_waddr_r <= 12'h000;
        dmem_wdata_r <= 8'h00;
        dmem_we_r <= 1'b0;
        move_data_r <= 8'h00;
    end else begin
        // read strobe covers phase two only
        dmem_rd_r <= q1 && pre_valid_r && !pre_second_r &&
                     (prefetch_r[15:12] == `QFP_OP_MOVE);
        if (q1) begin
            dmem_raddr_r <= prefetch_r[11:0];
        end
        if (q2 && is_move) begin
            move_data_r <= dmem_rdata;
        end
        // write strobe covers phase four of the tail cycle
        dmem_we_r <= q3 && exec_valid_r && exec_second_r &&
                     (word1_r[15:12] == `QFP_OP_MOVE);
        if (q3) begin
            dmem_waddr_r <= il[11:0];
            dmem_wdata_r <= move_data_r;
        end
    end
end

// ==========================================================================
// table read, pointer load, call and generic execute strobes
always @(posedge clk) begin
    if (!rst_n) begin
        table_read_latch_r <= 8'h00;
        table_byte_pointer_r <= `QFP_TPTR_RESET;
        tbl_busy_r <= 1'b0;
        ptr_load_r <= 1'b0;
        ptr_sel_r <= 2'b00;
        ptr_value_r <= 12'h000;
        call_push_r <= 1'b0;
        call_return_r <= `QFP_RESET_VECTOR;
        exec_other_r <= 1'b0;
    end else begin
        tbl_busy_r <= q2 && is_tbl;
        if (tbl_busy_r) begin
            // low byte at the even address
            table_read_latch_r <= table_byte_pointer_r[0] ?
                                  pmem_rdata[15:8] : pmem_rdata[7:0];
            if (il[0]) begin
                table_byte_pointer_r <= table_byte_pointer_r + 21'h000001;
            end
        end else if (tptr_load) begin
            // a load landing on a transfer loses; the pointer steps or holds as the transfer's low bit says
            table_byte_pointer_r <= tptr_value;
        end
        // tail word supplies the low eight literal bits, a lone tail does nothing
        ptr_load_r <= q4 && exec_valid_r && exec_second_r &&
                      (word1_r[15:8] == `QFP_OP_PTR);
        if (q4) begin
            ptr_sel_r <= word1_r[5:4];
            ptr_value_r <= {word1_r[3:0], il[7:0]};
        end
        call_push_r <= q4 && is_call;
        if (q4 && is_call) begin
            call_return_r <= exec_pc_r + `QFP_PC_STEP + `QFP_PC_STEP;
        end
        exec_other_r <= q1 && pre_valid_r && !pre_second_r &&
                        (prefetch_r[15:12] != `QFP_SECOND_TAG) &&
                        (prefetch_r[15:12] != `QFP_OP_MOVE);
    end
end

endmodule // qfp_pipeline

`default_nettype wire

// file: design/qfp_defines.vh
// Summary of operation
// - input clock divided by four into four non-overlapping phases per cycle.
// - program counter advances once per cycle in phase one, starting each fetch.
// - next instruction fetched and captured in phase four, executed next cycle.
// - execute cycle latches instruction in phase one, decodes and executes phases two-four.
// - data operand read in phase two, destination written in phase four.
// - fetch overlaps execution, so plain instructions complete in one cycle.
// - relative branch discards the fetched word and costs two cycles; jump and call keep it as their tail.
// - program memory byte addressed; instructions two or four bytes, low byte even.
// - program counter steps by two and its lowest bit always reads zero.
// - absolute call and jump load the word target into counter bits 20:1.
// - relative branch offset counts single-word instructions.
// - four two-word instructions; second word carries 1111 and 12 literal bits.
// - second word executed right after its first word supplies its literal data.
// - a 1111 word executed on its own acts as a no-operation.
// - table read uses table pointer as byte address, one byte per transfer.
`ifndef QFP_DEFINES_VH
`define QFP_DEFINES_VH

// ==========================================================================
// phases
`define QFP_PHASES 4
`define QFP_Q1 4'h1
`define QFP_Q2 4'h2
`define QFP_Q3 4'h4
`define QFP_Q4 4'h8

// ==========================================================================
// program counter and reset state
`define QFP_PC_W 21
`define QFP_PC_STEP 21'h000002
`define QFP_RESET_VECTOR 21'h000000
`define QFP_TPTR_RESET 21'h000000
`define QFP_NOP_WORD 16'h0000

// ==========================================================================
// opcode fields
`define QFP_OP_JUMP 8'hEF
`define QFP_OP_CALL 7'h76
`define QFP_OP_MOVE 4'hC
`define QFP_OP_PTR 8'hEE
`define QFP_OP_BRA 5'h1A
`define QFP_OP_TBLRD 15'h0004
`define QFP_SECOND_TAG 4'hF

`endif

// file: design/qfp_phase_gen.v
`timescale 1ns/10ps
`default_nettype none

module qfp_phase_gen (
    input wire clk,
    input wire rst_n,
    output reg [3:0] phase_r
);

`include "qfp_defines.vh"

// ==========================================================================
// one-hot rotation, one phase per input clock
always @(posedge clk) begin
    if (!rst_n) begin
        phase_r <= `QFP_Q1;
    end else begin
        phase_r <= {phase_r[2:0], phase_r[3]};
    end
end

endmodule // qfp_phase_gen

`default_nettype wire

// file: design/qfp_pipeline_top_note.v
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: tb/qfp_pipeline_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// port checker
module qfp_pipeline_chk #(
    parameter PC_W = 21
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] phase,
    input wire logic [PC_W-1:0] pc_r,
    input wire logic [PC_W-1:0] pmem_addr_r,
    input wire logic dmem_rd_r,
    input wire logic dmem_we_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_phase_onehot: assert property ($onehot(phase))
        else $error("phase not one-hot");
    a_phase_rotate: assert property (1'b1 |=> phase == {$past(phase[2:0]), $past(phase[3])})
        else $error("phase did not rotate");
    a_pc_even: assert property (!pc_r[0])
        else $error("pc lowest bit set");
    a_pc_step: assert property (phase == 4'h1 |=> pc_r == $past(pc_r) + 2)
        else $error("pc did not step by two in phase one");
    // pc steps in phase one and branches load in phase four, so any other move is a fault
    a_pc_moves: assert property ($changed(pc_r) |-> $past(phase) == 4'h1 || $past(phase) == 4'h8)
        else $error("pc changed in wrong phase");
    a_fetch_addr: assert property (phase == 4'h1 |=> pmem_addr_r == $past(pc_r))
        else $error("fetch address differs from pc");
    a_rd_q2: assert property (dmem_rd_r |-> phase == 4'h2)
        else $error("operand read outside phase two");
    a_we_q4: assert property (dmem_we_r |-> phase == 4'h8)
        else $error("data write outside phase four");
    a_rd_single: assert property (dmem_rd_r |=> !dmem_rd_r [*3])
        else $error("operand read longer than one cycle");
endmodule // qfp_pipeline_chk

bind qfp_pipeline qfp_pipeline_chk #(.PC_W(PC_W)) u_chk (.clk(clk), .rst_n(rst_n),
    .phase(phase), .pc_r(pc_r), .pmem_addr_r(pmem_addr_r), .dmem_rd_r(dmem_rd_r),
    .dmem_we_r(dmem_we_r));
`default_nettype wire

// file: tb/qfp_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// program rom and data ram
module qfp_mem_model (
    input wire logic clk,
    input wire logic [20:0] pmem_addr,
    output logic [15:0] pmem_rdata,
    input wire logic [11:0] dmem_raddr,
    input wire logic dmem_rd,
    output logic [7:0] dmem_rdata
);
    logic [7:0] last_r;
    // words with low byte at the even address
    always_comb begin
        case (pmem_addr[20:1])
            20'h00000: pmem_rdata = 16'hC123;
            20'h00001: pmem_rdata = 16'hF456;
            20'h00002: pmem_rdata = 16'hD001;
            20'h00003: pmem_rdata = 16'hC111;
            20'h00004: pmem_rdata = 16'hF789;
            20'h00005: pmem_rdata = 16'hEF10;
            20'h00006: pmem_rdata = 16'hF000;
            20'h00007: pmem_rdata = 16'hC2AB;
            20'h00010: pmem_rdata = 16'h0009;
            20'h00011: pmem_rdata = 16'hEE1A;
            20'h00012: pmem_rdata = 16'hF0BC;
            20'h00013: pmem_rdata = 16'hEC20;
            20'h00014: pmem_rdata = 16'hF000;
            20'h00020: pmem_rdata = 16'hD7FF;
            default: pmem_rdata = 16'h0000;
        endcase
    end
    // unselected read port shows flipped stale data, not a held value
    assign dmem_rdata = dmem_rd ? (dmem_raddr == 12'h123 ? 8'h3C : 8'h00) : ~last_r;
    always @(posedge clk) begin
        last_r <= dmem_rdata;
    end
endmodule // qfp_mem_model
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// testbench
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tptr_load = 1'b0;
    logic [20:0] tptr_value = 21'h000000;
    wire [15:0] pmem_rdata;
    wire [7:0] dmem_rdata;
    wire [3:0] phase;
    wire [20:0] pc_r, pmem_addr_r, tbp;
    wire [11:0] raddr, waddr;
    wire [7:0] wdata, tlat;
    wire rd, we, xv;
    wire [15:0] latch;
    wire eo, pl, cp;
    wire [1:0] psel;
    wire [11:0] pval;
    wire [20:0] cret;
    integer pl_n = 0, cp_n = 0, eo_n = 0, eo_bad = 0;
    logic [11:0] pv_seen = 12'h000;
    logic [1:0] ps_seen = 2'b00;
    logic [20:0] cr_seen = 21'h000000;
    integer miscompares = 0, check_count = 0, cycles = 0, rd_n = 0, we_n = 0, bad_n = 0, n;
    logic [11:0] rd_seen = 12'h000;

    always #12.5 clk = ~clk;

    qfp_pipeline uut (.clk(clk), .rst_n(rst_n), .pmem_rdata(pmem_rdata),
        .dmem_rdata(dmem_rdata), .tptr_load(tptr_load), .tptr_value(tptr_value),
        .phase(phase), .pc_r(pc_r), .pmem_addr_r(pmem_addr_r), .dmem_raddr_r(raddr),
        .dmem_rd_r(rd), .dmem_waddr_r(waddr), .dmem_wdata_r(wdata), .dmem_we_r(we),
        .instruction_latch_r(latch), .exec_valid_r(xv), .exec_other_r(eo),
        .table_read_latch_r(tlat), .table_byte_pointer_r(tbp), .ptr_load_r(pl),
        .ptr_sel_r(psel), .ptr_value_r(pval), .call_push_r(cp), .call_return_r(cret));
    qfp_mem_model u_mem (.clk(clk), .pmem_addr(pmem_addr_r), .pmem_rdata(pmem_rdata),
        .dmem_raddr(raddr), .dmem_rd(rd), .dmem_rdata(dmem_rdata));

    // strobe tally; flushed or skipped words must never run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (rst_n && rd === 1'b1) begin
            rd_n <= rd_n + 1;
            rd_seen <= raddr;
        end
        if (rst_n && we === 1'b1) we_n <= we_n + 1;
        if (rst_n && pl === 1'b1) begin
            pl_n <= pl_n + 1;
            ps_seen <= psel;
            pv_seen <= pval;
        end
        if (rst_n && cp === 1'b1) begin
            cp_n <= cp_n + 1;
            cr_seen <= cret;
        end
        // hook must stay quiet for tails, moves and empty slots
        if (rst_n && eo === 1'b1) begin
            eo_n <= eo_n + 1;
            if (xv !== 1'b1 || latch[15:12] === 4'hF || latch[15:12] === 4'hC) eo_bad <= eo_bad + 1;
        end
        if (rst_n && xv === 1'b1 && (latch === 16'hC111 || latch === 16'hC2AB)) bad_n <= bad_n + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            results();
        end
    end

    task automatic chk(input [31:0] exp, input [31:0] got, input [8*10-1:0] name);
        check_count = check_count + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic t_move;
        n = 0;
        while (we !== 1'b1 && n < 100) begin
            @(negedge clk);
            n = n + 1;
        end
        chk(32'h1, rd_n, "reads");
        chk(32'h123, rd_seen, "rd_addr");
        chk(32'h456, waddr, "wr_addr");
        chk(32'h3C, wdata, "wr_data");
        $display("test move done");
    endtask

    task automatic t_skip;
        n = 0;
        while (!(xv === 1'b1 && latch === 16'h0009) && n < 200) begin
            @(negedge clk);
            n = n + 1;
        end
        chk(32'h0009, latch, "jump_tgt");
        chk(32'h1, rd_n, "nop_reads");
        chk(32'h1, we_n, "nop_writes");
        chk(32'h0, bad_n, "flushed");
        $display("test skip done");
    endtask

    task automatic t_table;
        repeat (8) @(negedge clk);
        chk(32'hC2, tlat, "tbl_byte");
        chk(32'h10, tbp, "tbl_ptr");
        $display("test table done");
    endtask

    task automatic t_call;
        n = 0;
        while (!(xv === 1'b1 && latch === 16'hD7FF) && n < 200) begin
            @(negedge clk);
            n = n + 1;
        end
        chk(32'hD7FF, latch, "call_tgt");
        chk(32'h1, cp_n, "pushes");
        chk(32'h2A, cr_seen, "ret_addr");
        chk(32'h1, pl_n, "ptr_loads");
        chk(32'h1, ps_seen, "ptr_sel");
        chk(32'hABC, pv_seen, "ptr_value");
        chk(32'h0, eo_bad, "other_bad");
        chk(32'h1, eo_n != 0, "other_seen");
        $display("test call done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        tptr_load = 1'b1;
        tptr_value = 21'h00000F;
        @(negedge clk);
        tptr_load = 1'b0;
        t_move();
        t_skip();
        t_table();
        t_call();
        results();
    end
endmodule // tb
`default_nettype wire
